//--- hw/port_pins_map.vh
// Register map, field positions and reset values of the port and clock block.
// Included by the design file; holds definitions only.
`ifndef PORT_PINS_MAP_VH
`define PORT_PINS_MAP_VH

// Byte offsets on the register bus (one aligned word each)
`define OFS_P0_DATA   8'h00
`define OFS_P0_DIR    8'h04
`define OFS_P1_DATA   8'h08
`define OFS_P1_DIR    8'h0C
`define OFS_P2_DATA   8'h10
`define OFS_P3_DATA   8'h14
`define OFS_P3_DIR    8'h18
`define OFS_P6_DATA   8'h1C
`define OFS_P6_DIR    8'h20
`define OFS_P7_DATA   8'h24
`define OFS_P7_DIR    8'h28
`define OFS_PULLUP    8'h2C
`define OFS_RTO_CTRL  8'h30
`define OFS_RTO_BUF   8'h34
`define OFS_CLK_DIV   8'h38
`define OFS_OSC_CFG   8'h3C
`define ADDR_LSB      2
`define ADDR_MSB      7

// Direction masks: set bits have a per-pin direction bit
`define DIRMASK_FULL  8'hFF
`define DIRMASK_P6    8'hC0
// Port 6 pins 0..3 are output-only, 4..5 do not exist
`define P6_OUT_ONLY   8'h0F
// Port 2 pull-up group covers pins 2..7
`define P2_PU_GROUP   8'hFC

// Pull-up register bits (one per port except port 7)
`define PU_P0 0
`define PU_P1 1
`define PU_P2 2
`define PU_P3 3
`define PU_P6 6
`define PU_W  7

// Real-time output control bits
`define RTO_LO_EN  0
`define RTO_HI_EN  1
`define RTO_LO_SRC 2
`define RTO_HI_SRC 3
`define RTO_W      4

// Clock divider: fclk = fxx / 2^n, n clamped to DIV_MAX
`define DIV_W   3
`define DIV_MAX 3'h4
`define CNT_W   4

// Oscillator configuration: settle code in [2:0], external clock select bit
`define OSC_SETTLE_W 3
`define OSC_EXTERNAL_CLOCK_SELECT_BIT 7

`define RST_BYTE 8'h00
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2
`endif

//--- hw/port_pins_and_clock_divider.v
// Port pin logic (ports 0,1,2,3,6,7), real-time output on port 0 and the
// internal clock divider, all behind an AXI4-Lite register slave.
// Assumes pad cells outside resolve out/enable/pull-up; pin inputs synchronous.
`timescale 1ns/1ps
`include "port_pins_map.vh"

////////////////////////////////////////////////////////////////////////////////
// One 8-pin bank: output latch, direction, pin readback and pull-up gating
module port_bank #(
  parameter [7:0] DIR_MASK  = 8'hFF,  // Pins with a direction bit
  parameter [7:0] FORCE_OUT = 8'h00   // Pins that always drive
) (
  input  wire       mclk_i,      // Clock
  input  wire       nrst_i,      // Async reset, active low
  input  wire       data_we_i,   // Software write of output latch
  input  wire       dir_we_i,    // Software write of direction
  input  wire [7:0] wdata_i,     // Write data
  input  wire [7:0] load_en_i,   // Hardware load per pin
  input  wire [7:0] load_val_i,  // Hardware load value
  input  wire [7:0] pin_i,       // Pin levels
  input  wire       pu_en_i,     // Port pull-up enable
  output wire [7:0] pin_o,       // Pin output values
  output wire [7:0] pin_oe_o,    // Pin drive enables
  output wire [7:0] pu_o,        // Pull-up connect per pin
  output wire [7:0] rd_data_o,   // Readback of pin or latch
  output wire [7:0] dir_o        // Direction register
);
  reg  [7:0] out_q;
  reg  [7:0] dir_q;
  wire [7:0] drive;
  integer    i;

  // Hardware load wins over a software write in the same cycle, so a trigger is never lost
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out_q <= `RST_BYTE;
      dir_q <= `RST_BYTE;
    end else begin
      for (i = 0; i < 8; i = i + 1) begin
        if (load_en_i[i]) begin
          out_q[i] <= load_val_i[i];
        end else if (data_we_i) begin
          out_q[i] <= wdata_i[i];
        end
      end
      if (dir_we_i) begin
        dir_q <= wdata_i & DIR_MASK;
      end
    end
  end

  assign drive     = dir_q | FORCE_OUT;
  assign pin_o     = out_q & drive;
  assign pin_oe_o  = drive;
  // Pull-up only where the pin is an input; output-only pins never get one
  assign pu_o      = {8{pu_en_i}} & ~drive & (DIR_MASK | FORCE_OUT);
  assign rd_data_o = (out_q & drive) | (pin_i & ~drive);
  assign dir_o     = dir_q;
endmodule

////////////////////////////////////////////////////////////////////////////////
// Top level
module port_pins_and_clock_divider (
  input  wire        mclk_i,            // 200 MHz clock (fxx)
  input  wire        nrst_i,            // Async reset, active low
  // AXI4-Lite slave
  input  wire [7:0]  s_axi_awaddr,      // Write address
  input  wire        s_axi_awvalid,     // Write address valid
  output wire        s_axi_awready,     // Write address ready
  input  wire [31:0] s_axi_wdata,       // Write data
  input  wire [3:0]  s_axi_wstrb,       // Write strobes
  input  wire        s_axi_wvalid,      // Write data valid
  output wire        s_axi_wready,      // Write data ready
  output wire [1:0]  s_axi_bresp,       // Write response
  output wire        s_axi_bvalid,      // Write response valid
  input  wire        s_axi_bready,      // Write response ready
  input  wire [7:0]  s_axi_araddr,      // Read address
  input  wire        s_axi_arvalid,     // Read address valid
  output wire        s_axi_arready,     // Read address ready
  output wire [31:0] s_axi_rdata,       // Read data
  output wire [1:0]  s_axi_rresp,       // Read response
  output wire        s_axi_rvalid,      // Read data valid
  input  wire        s_axi_rready,      // Read data ready
  // Port pins
  input  wire [7:0]  port_zero_pins_i,  // Port 0 pin levels
  output wire [7:0]  port_zero_pins_o,  // Port 0 outputs
  output wire [7:0]  port_zero_oe_o,    // Port 0 drive enables
  output wire [7:0]  port_zero_pu_o,    // Port 0 pull-ups
  input  wire [7:0]  p1_i,              // Port 1 pin levels
  output wire [7:0]  p1_o,              // Port 1 outputs
  output wire [7:0]  p1_oe_o,           // Port 1 drive enables
  output wire [7:0]  p1_pu_o,           // Port 1 pull-ups
  input  wire [7:0]  p2_i,              // Port 2 pin levels (input only)
  output wire [7:0]  p2_pu_o,           // Port 2 pull-ups
  input  wire [7:0]  p3_i,              // Port 3 pin levels
  output wire [7:0]  p3_o,              // Port 3 outputs
  output wire [7:0]  p3_oe_o,           // Port 3 drive enables
  output wire [7:0]  p3_pu_o,           // Port 3 pull-ups
  input  wire [7:0]  p6_i,              // Port 6 pin levels (6,7 used)
  output wire [7:0]  p6_o,              // Port 6 outputs
  output wire [7:0]  p6_oe_o,           // Port 6 drive enables
  output wire [7:0]  p6_pu_o,           // Port 6 pull-ups
  input  wire [7:0]  p7_i,              // Port 7 pin levels
  output wire [7:0]  p7_o,              // Port 7 outputs
  output wire [7:0]  p7_oe_o,           // Port 7 drive enables
  // Real-time output triggers and clock generation
  input  wire        timer1_match_i,    // Timer/counter 1 coincidence pulse
  input  wire        ext_irq_i,         // External interrupt pulse
  output wire        fclk_tick_o,       // One pulse per fclk period
  output wire        external_clock_select_o, // Oscillator pad mode
  output wire [2:0]  osc_settle_sel_o   // Settle time code
);
  ////////////////////////////////////////////////////////////////////////////
  // Bus slave state
  reg                 aw_full_q;
  reg  [7:0]          aw_addr_q;
  reg                 w_full_q;
  reg  [31:0]         w_data_q;
  reg  [3:0]          w_strb_q;
  reg                 bvalid_q;
  reg  [1:0]          bresp_q;
  reg                 rvalid_q;
  reg  [31:0]         rdata_q;
  reg  [1:0]          rresp_q;
  reg  [`PU_W-1:0]    pullup_q;
  reg  [`RTO_W-1:0]   rto_ctrl_q;
  reg  [7:0]          rto_buf_q;
  reg  [`DIV_W-1:0]   div_q;
  reg  [7:0]          osc_cfg_q;
  reg  [`CNT_W-1:0]   div_cnt_q;
  reg  [`CNT_W-1:0]   div_mask;
  reg  [31:0]         rd_mux;
  reg                 rd_hit;
  reg                 wr_hit;
  wire                wr_go;
  wire                wr_lane;
  wire [7:0]          wr_byte;
  wire                rd_go;
  wire [7:0]          p0_rd, p1_rd, p3_rd, p6_rd, p7_rd, p0_dir;
  wire                lo_trig, hi_trig;
  wire [7:0]          rto_load;
  wire [7:0]          p3_oe_w;

  assign s_axi_awready = ~aw_full_q;
  assign s_axi_wready  = ~w_full_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // A write is performed once both halves are held and the response slot is free
  assign wr_go   = aw_full_q & w_full_q & ~bvalid_q;
  assign wr_lane = wr_go & w_strb_q[0];
  assign wr_byte = w_data_q[7:0];
  assign rd_go   = s_axi_arvalid & ~rvalid_q;

  // Address and data are captured independently, in either order
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= `RST_BYTE;
      w_full_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_full_q) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_q) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Decode of writable offsets; read-only port 2 answers as unmapped on write
  always @* begin
    case (aw_addr_q)
      `OFS_P0_DATA, `OFS_P0_DIR, `OFS_P1_DATA, `OFS_P1_DIR,
      `OFS_P3_DATA, `OFS_P3_DIR, `OFS_P6_DATA, `OFS_P6_DIR,
      `OFS_P7_DATA, `OFS_P7_DIR, `OFS_PULLUP, `OFS_RTO_CTRL,
      `OFS_RTO_BUF, `OFS_CLK_DIV, `OFS_OSC_CFG: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers kept outside the pin banks
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pullup_q   <= {`PU_W{1'b0}};
      rto_ctrl_q <= {`RTO_W{1'b0}};
      rto_buf_q  <= `RST_BYTE;
      div_q      <= {`DIV_W{1'b0}};
      osc_cfg_q  <= `RST_BYTE;
    end else if (wr_lane) begin
      case (aw_addr_q)
        `OFS_PULLUP:   pullup_q   <= wr_byte[`PU_W-1:0];
        `OFS_RTO_CTRL: rto_ctrl_q <= wr_byte[`RTO_W-1:0];
        `OFS_RTO_BUF:  rto_buf_q  <= wr_byte;
        // Clamp so the divider never selects a ratio it cannot make
        `OFS_CLK_DIV:  div_q <= (wr_byte[`DIV_W-1:0] > `DIV_MAX) ? `DIV_MAX
                                                                 : wr_byte[`DIV_W-1:0];
        `OFS_OSC_CFG:  osc_cfg_q  <= wr_byte;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Real-time output: each nibble has its own enable and trigger source
  assign lo_trig = rto_ctrl_q[`RTO_LO_EN] &
                   (rto_ctrl_q[`RTO_LO_SRC] ? ext_irq_i : timer1_match_i);
  assign hi_trig = rto_ctrl_q[`RTO_HI_EN] &
                   (rto_ctrl_q[`RTO_HI_SRC] ? ext_irq_i : timer1_match_i);
  assign rto_load = {{4{hi_trig}}, {4{lo_trig}}};

  ////////////////////////////////////////////////////////////////////////////
  // Pin banks
  port_bank #(.DIR_MASK(`DIRMASK_FULL), .FORCE_OUT(`RST_BYTE)) u_p0 (
    .mclk_i(mclk_i), .nrst_i(nrst_i),
    .data_we_i(wr_lane && aw_addr_q == `OFS_P0_DATA),
    .dir_we_i(wr_lane && aw_addr_q == `OFS_P0_DIR),
    .wdata_i(wr_byte), .load_en_i(rto_load), .load_val_i(rto_buf_q),
    .pin_i(port_zero_pins_i), .pu_en_i(pullup_q[`PU_P0]),
    .pin_o(port_zero_pins_o), .pin_oe_o(port_zero_oe_o), .pu_o(port_zero_pu_o),
    .rd_data_o(p0_rd), .dir_o(p0_dir));

  port_bank #(.DIR_MASK(`DIRMASK_FULL), .FORCE_OUT(`RST_BYTE)) u_p1 (
    .mclk_i(mclk_i), .nrst_i(nrst_i),
    .data_we_i(wr_lane && aw_addr_q == `OFS_P1_DATA),
    .dir_we_i(wr_lane && aw_addr_q == `OFS_P1_DIR),
    .wdata_i(wr_byte), .load_en_i(`RST_BYTE), .load_val_i(`RST_BYTE),
    .pin_i(p1_i), .pu_en_i(pullup_q[`PU_P1]),
    .pin_o(p1_o), .pin_oe_o(p1_oe_o), .pu_o(p1_pu_o),
    .rd_data_o(p1_rd), .dir_o());

  port_bank #(.DIR_MASK(`DIRMASK_FULL), .FORCE_OUT(`RST_BYTE)) u_p3 (
    .mclk_i(mclk_i), .nrst_i(nrst_i),
    .data_we_i(wr_lane && aw_addr_q == `OFS_P3_DATA),
    .dir_we_i(wr_lane && aw_addr_q == `OFS_P3_DIR),
    .wdata_i(wr_byte), .load_en_i(`RST_BYTE), .load_val_i(`RST_BYTE),
    .pin_i(p3_i), .pu_en_i(pullup_q[`PU_P3]),
    .pin_o(p3_o), .pin_oe_o(p3_oe_w), .pu_o(p3_pu_o),
    .rd_data_o(p3_rd), .dir_o());

  // Port 6: pins 0..3 always drive, only 6 and 7 have a direction bit
  port_bank #(.DIR_MASK(`DIRMASK_P6), .FORCE_OUT(`P6_OUT_ONLY)) u_p6 (
    .mclk_i(mclk_i), .nrst_i(nrst_i),
    .data_we_i(wr_lane && aw_addr_q == `OFS_P6_DATA),
    .dir_we_i(wr_lane && aw_addr_q == `OFS_P6_DIR),
    .wdata_i(wr_byte), .load_en_i(`RST_BYTE), .load_val_i(`RST_BYTE),
    .pin_i(p6_i), .pu_en_i(pullup_q[`PU_P6]),
    .pin_o(p6_o), .pin_oe_o(p6_oe_o), .pu_o(p6_pu_o),
    .rd_data_o(p6_rd), .dir_o());

  // Port 7 has no software pull-up, so its enable is tied off
  port_bank #(.DIR_MASK(`DIRMASK_FULL), .FORCE_OUT(`RST_BYTE)) u_p7 (
    .mclk_i(mclk_i), .nrst_i(nrst_i),
    .data_we_i(wr_lane && aw_addr_q == `OFS_P7_DATA),
    .dir_we_i(wr_lane && aw_addr_q == `OFS_P7_DIR),
    .wdata_i(wr_byte), .load_en_i(`RST_BYTE), .load_val_i(`RST_BYTE),
    .pin_i(p7_i), .pu_en_i(1'b0),
    .pin_o(p7_o), .pin_oe_o(p7_oe_o), .pu_o(),
    .rd_data_o(p7_rd), .dir_o());

  assign p3_oe_o = p3_oe_w;
  // Port 2 never drives; its single pull-up bit covers pins 2..7 together
  assign p2_pu_o = {8{pullup_q[`PU_P2]}} & `P2_PU_GROUP;

  ////////////////////////////////////////////////////////////////////////////
  // Clock divider: tick every 2^n source cycles; a tick each cycle when n is 0
  always @* begin
    case (div_q)
      3'h0:    div_mask = 4'h0;
      3'h1:    div_mask = 4'h1;
      3'h2:    div_mask = 4'h3;
      3'h3:    div_mask = 4'h7;
      default: div_mask = 4'hF;
    endcase
  end

  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_cnt_q <= {`CNT_W{1'b0}};
    end else begin
      div_cnt_q <= div_cnt_q + {{(`CNT_W-1){1'b0}}, 1'b1};
    end
  end

  assign fclk_tick_o             = ((div_cnt_q & div_mask) == div_mask);
  assign external_clock_select_o = osc_cfg_q[`OSC_EXTERNAL_CLOCK_SELECT_BIT];
  assign osc_settle_sel_o        = osc_cfg_q[`OSC_SETTLE_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Read path: port data offsets return pin level for inputs, latch for outputs
  always @* begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `OFS_P0_DATA:  rd_mux = {24'h000000, p0_rd};
      `OFS_P0_DIR:   rd_mux = {24'h000000, p0_dir};
      `OFS_P1_DATA:  rd_mux = {24'h000000, p1_rd};
      `OFS_P1_DIR:   rd_mux = {24'h000000, p1_oe_o};
      `OFS_P2_DATA:  rd_mux = {24'h000000, p2_i};
      `OFS_P3_DATA:  rd_mux = {24'h000000, p3_rd};
      `OFS_P3_DIR:   rd_mux = {24'h000000, p3_oe_w};
      `OFS_P6_DATA:  rd_mux = {24'h000000, p6_rd};
      `OFS_P6_DIR:   rd_mux = {24'h000000, p6_oe_o & `DIRMASK_P6};
      `OFS_P7_DATA:  rd_mux = {24'h000000, p7_rd};
      `OFS_P7_DIR:   rd_mux = {24'h000000, p7_oe_o};
      `OFS_PULLUP:   rd_mux = {25'h0, pullup_q};
      `OFS_RTO_CTRL: rd_mux = {28'h0000000, rto_ctrl_q};
      `OFS_RTO_BUF:  rd_mux = {24'h000000, rto_buf_q};
      `OFS_CLK_DIV:  rd_mux = {29'h0, div_q};
      `OFS_OSC_CFG:  rd_mux = {24'h000000, osc_cfg_q};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // One read in flight; address accepted only while the data slot is empty
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `RESP_OKAY;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
endmodule

//--- verif/port_pins_sva.sv
// Checker for the port and clock block: bus answers, pin gating, clock outputs.
// Assumes it is bound into port_pins_and_clock_divider and sees only its ports.
`timescale 1ns/1ps
module port_pins_sva (
  input wire        mclk_i,                 // Clock
  input wire        nrst_i,                 // Reset, active low
  input wire        s_axi_arready,          // Read address ready
  input wire        s_axi_bvalid,           // Write response valid
  input wire        s_axi_bready,           // Write response ready
  input wire [1:0]  s_axi_bresp,            // Write response
  input wire        s_axi_rvalid,           // Read data valid
  input wire        s_axi_rready,           // Read data ready
  input wire [31:0] s_axi_rdata,            // Read data
  input wire [7:0]  port_zero_pins_o,       // Port 0 outputs
  input wire [7:0]  port_zero_oe_o,         // Port 0 enables
  input wire [7:0]  port_zero_pu_o,         // Port 0 pull-ups
  input wire [7:0]  p1_o,                   // Port 1 outputs
  input wire [7:0]  p1_oe_o,                // Port 1 enables
  input wire [7:0]  p1_pu_o,                // Port 1 pull-ups
  input wire [7:0]  p2_pu_o,                // Port 2 pull-ups
  input wire [7:0]  p6_oe_o,                // Port 6 enables
  input wire [7:0]  p6_pu_o,                // Port 6 pull-ups
  input wire        fclk_tick_o,            // Divided clock tick
  input wire        external_clock_select_o // Oscillator pad mode
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  // A register write lands at the edge where its response rises
  sequence wr_done;
    $rose(s_axi_bvalid);
  endsequence
  // Direction and pull-up gating on the pins
  a_p6_fixed_dir: assert property (p6_oe_o[5:0] == 6'h0F)
    else $error("port 6 fixed directions wrong");
  // Ports 0 and 1 are each gated by their own enables; ports may differ in direction
  a_out_gated: assert property (((port_zero_pins_o & ~port_zero_oe_o)
    | (p1_o & ~p1_oe_o)) == 8'h00)
    else $error("output value on an undriven pin");
  a_pu_inputs: assert property (((port_zero_pu_o & port_zero_oe_o)
    | (p1_pu_o & p1_oe_o) | (p6_pu_o & p6_oe_o) | (p6_pu_o & 8'h3F)) == 8'h00)
    else $error("pull-up on a driving pin");
  a_p2_group: assert property (p2_pu_o == 8'h00 || p2_pu_o == 8'hFC)
    else $error("port 2 pull-up not one group");
  // Tick period never exceeds the largest division of sixteen
  a_tick_period: assert property (fclk_tick_o |-> ##[1:16] fclk_tick_o)
    else $error("divided tick missing");
  // Pad mode moves only when a register write completes
  a_external_clock_select_write: assert property ($changed(external_clock_select_o) |-> wr_done)
    else $error("clock select changed without a write");
  // Answers stand until taken; a pending read blocks the next address
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
endmodule

bind port_pins_and_clock_divider port_pins_sva port_pins_sva_i (.*);

//--- verif/pin_board.sv
// Board model of one 8-pin port: resolves drive, pull-up and outside level.
// Assumes the design gives value, enable and pull-up per pin; ext is the board.
`timescale 1ns/1ps
module pin_board (
  input  wire [7:0] out_i, // Design output values
  input  wire [7:0] oe_i,  // Design drive enables
  input  wire [7:0] pu_i,  // Pull-up connect
  input  wire [7:0] ext_i, // Level the board puts on free pins
  output wire [7:0] lvl_o  // Resolved pin level
);
  // Driven pin shows the design; a pulled pin wins over the weak board level
  assign lvl_o = (oe_i & out_i) | (~oe_i & (pu_i | ext_i));
endmodule

//--- verif/tb_top.sv
// Testbench of the port and clock block: register tasks and one task a scenario.
// Assumes pin_board models the pads and the checker is bound to the design.
`timescale 1ns/1ps
`include "port_pins_map.vh"
module tb_top;
  logic        mclk_i = 1'b0, nrst_i = 1'b0, tmr = 1'b0, eirq = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, board = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire         awready, wready, bvalid, arready, rvalid, tick, external_clock_select;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire [2:0]   settle;
  wire [7:0]   o0, e0, u0, o1, e1, u1, u2, o3, e3, u3, o6, e6, u6, o7, e7;
  wire [7:0]   l0, l1, l2, l3, l6, l7;
  int          error_cnt = 0, total_checks = 0;

  port_pins_and_clock_divider port_pins_and_clock_divider_i (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .port_zero_pins_i(l0), .port_zero_pins_o(o0), .port_zero_oe_o(e0), .port_zero_pu_o(u0),
    .p1_i(l1), .p1_o(o1), .p1_oe_o(e1), .p1_pu_o(u1), .p2_i(l2), .p2_pu_o(u2),
    .p3_i(l3), .p3_o(o3), .p3_oe_o(e3), .p3_pu_o(u3), .p6_i(l6), .p6_o(o6), .p6_oe_o(e6),
    .p6_pu_o(u6), .p7_i(l7), .p7_o(o7), .p7_oe_o(e7), .timer1_match_i(tmr), .ext_irq_i(eirq),
    .fclk_tick_o(tick), .external_clock_select_o(external_clock_select), .osc_settle_sel_o(settle));
  // Pads of each port; port 2 never drives and port 7 has no pull-up
  pin_board pin_board_i0 (.out_i(o0), .oe_i(e0), .pu_i(u0), .ext_i(board), .lvl_o(l0));
  pin_board pin_board_i1 (.out_i(o1), .oe_i(e1), .pu_i(u1), .ext_i(board), .lvl_o(l1));
  pin_board pin_board_i2 (.out_i(8'h00), .oe_i(8'h00), .pu_i(u2), .ext_i(board), .lvl_o(l2));
  pin_board pin_board_i3 (.out_i(o3), .oe_i(e3), .pu_i(u3), .ext_i(board), .lvl_o(l3));
  pin_board pin_board_i6 (.out_i(o6), .oe_i(e6), .pu_i(u6), .ext_i(board), .lvl_o(l6));
  pin_board pin_board_i7 (.out_i(o7), .oe_i(e7), .pu_i(8'h00), .ext_i(board), .lvl_o(l7));

  always #2.5 mclk_i = ~mclk_i;

  ////////////////////////////////////////////////////////////////////////////
  task summarize;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input [31:0] got, input [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Write: address and data offered together, each dropped when taken
  task automatic wr(input [7:0] a, input [7:0] d, input [1:0] er);
    int n;
    @(posedge mclk_i);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    {awvalid, wvalid, bready} <= 3'b111;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (n == 40) begin error_cnt++; summarize; end
    chk(bresp, er);
  endtask
  // Read and compare data and response where the answer is taken
  task automatic rdc(input [7:0] a, input [31:0] exp, input [1:0] er);
    int n;
    @(posedge mclk_i);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk_i);
      if (arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    if (n == 40) begin error_cnt++; summarize; end
    chk(rdata, exp);
    chk(rresp, er);
  endtask
  // One-cycle trigger pulses, then port 0 is looked at once settled
  task automatic pulse(input t, input e, input [7:0] exp);
    @(posedge mclk_i);
    {tmr, eirq} <= {t, e};
    @(posedge mclk_i);
    {tmr, eirq} <= 2'b00;
    @(posedge mclk_i);
    chk(o0, exp);
  endtask
  // Edges from one sampled tick to the next; the bound cuts a dead divider
  task automatic gap(output int g);
    int k;
    for (k = 0; k < 40 && tick !== 1'b1; k++) @(posedge mclk_i);
    g = 0;
    do begin @(posedge mclk_i); g++; end while (tick !== 1'b1 && g < 40);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    chk(e6, 8'h0F);
    chk({o0, e0, u0, u2}, 32'h0);
    rdc(`OFS_P0_DIR, 32'h0, `RESP_OKAY);
  endtask
  // Mixed directions: latch shows on outputs, board level on inputs
  task t_dir;
    logic [7:0] da [4];
    int i;
    da = '{`OFS_P0_DATA, `OFS_P1_DATA, `OFS_P3_DATA, `OFS_P7_DATA};
    @(posedge mclk_i) board <= 8'h3C;
    for (i = 0; i < 4; i++) begin
      wr(da[i] + 8'h04, 8'hA5, `RESP_OKAY);
      wr(da[i], 8'hF0, `RESP_OKAY);
      rdc(da[i], 32'hB8, `RESP_OKAY);
    end
    chk({o0, e0, o1, e1}, 32'hA0A5A0A5);
    chk({o3, e3, o7, e7}, 32'hA0A5A0A5);
    wr(`OFS_P6_DIR, 8'hFF, `RESP_OKAY);
    wr(`OFS_P6_DATA, 8'hFF, `RESP_OKAY);
    chk({o6, e6}, 16'hCFCF);
  endtask
  task t_pull;
    wr(`OFS_PULLUP, 8'hFF, `RESP_OKAY);
    chk({u0, u1, u3, u6}, 32'h5A5A5A00);
    chk(u2, 8'hFC);
    wr(`OFS_P6_DIR, 8'h40, `RESP_OKAY);
    chk({e6, u6}, 16'h4F80);
    wr(`OFS_PULLUP, 8'h00, `RESP_OKAY);
    rdc(`OFS_P2_DATA, 32'h3C, `RESP_OKAY);
    wr(`OFS_PULLUP, 8'h04, `RESP_OKAY);
    chk({u0, u2}, 16'h00FC);
    wr(`OFS_P2_DATA, 8'h11, `RESP_SLVERR);
  endtask
  // Low group on the timer, high group on the external event; then low on the event alone, then both on the timer
  task t_rto;
    wr(`OFS_P0_DIR, 8'hFF, `RESP_OKAY);
    wr(`OFS_P0_DATA, 8'h00, `RESP_OKAY);
    wr(`OFS_RTO_BUF, 8'h3C, `RESP_OKAY);
    wr(`OFS_RTO_CTRL, 8'h0B, `RESP_OKAY);
    pulse(1'b1, 1'b0, 8'h0C);
    pulse(1'b0, 1'b1, 8'h3C);
    wr(`OFS_RTO_BUF, 8'hA5, `RESP_OKAY);
    pulse(1'b1, 1'b0, 8'h35);
    pulse(1'b0, 1'b1, 8'hA5);
    wr(`OFS_RTO_CTRL, 8'h05, `RESP_OKAY);
    wr(`OFS_RTO_BUF, 8'hFF, `RESP_OKAY);
    pulse(1'b1, 1'b0, 8'hA5);
    pulse(1'b0, 1'b1, 8'hAF);
    // Both groups on the timer, so the high group's timer source is used too
    wr(`OFS_RTO_CTRL, 8'h03, `RESP_OKAY);
    wr(`OFS_RTO_BUF, 8'h5A, `RESP_OKAY);
    pulse(1'b1, 1'b0, 8'h5A);
  endtask
  // Division by each power of two; a code above four is clamped
  task t_div;
    int n, g;
    for (n = 0; n < 6; n++) begin
      wr(`OFS_CLK_DIV, n[7:0], `RESP_OKAY);
      gap(g);
      gap(g);
      chk(g, 1 << ((n > 4) ? 4 : n));
    end
  endtask
  task t_osc;
    wr(`OFS_OSC_CFG, 8'h85, `RESP_OKAY);
    chk({external_clock_select, settle}, 4'hD);
    wr(`OFS_OSC_CFG, 8'h06, `RESP_OKAY);
    chk({external_clock_select, settle}, 4'h6);
  endtask
  task t_bus;
    wr(8'h40, 8'h55, `RESP_SLVERR);
    rdc(8'h40, 32'h0, `RESP_SLVERR);
  endtask

  initial begin
    repeat (2) @(posedge mclk_i);
    nrst_i <= 1'b1;
    t_reset;
    t_dir;
    t_pull;
    t_rto;
    t_div;
    t_osc;
    t_bus;
    summarize;
  end
endmodule
